/* File: common/spi_msg_pkg.sv */
package spi_msg_pkg;

    // Direction codes that open every command word.
    localparam logic [1:0] DIR_HOST = 2'h2;
    localparam logic [1:0] DIR_NODE = 2'h1;

    // Length field of every command word: two bytes.
    localparam logic [1:0] LEN_CODE = 2'h2;

    // Field positions inside the first command byte.
    localparam int CMD_DIR_LSB = 6;
    localparam int CMD_LEN_LSB = 4;
    localparam int CMD_OP_LSB = 0;

    // Opcodes of the four exchange pairs.
    localparam logic [3:0] OP_HOST_SIZE = 4'h9;
    localparam logic [3:0] OP_HOST_HDR = 4'hA;
    localparam logic [3:0] OP_NODE_SIZE = 4'hB;
    localparam logic [3:0] OP_NODE_HDR = 4'hC;

    // Constant second byte of every header word.
    localparam logic [7:0] HDR_CONST = 8'h01;

    // Default receive queue space reported to the host.
    localparam logic [7:0] RX_SPACE_DEF = 8'hFF;

    // Message type codes and lengths.
    localparam logic [15:0] TYPE_LINK_OPEN = 16'h4032;
    localparam logic [15:0] TYPE_ACK = 16'h0030;
    localparam logic [7:0] LINK_OPEN_LEN = 8'h0C;
    localparam logic [7:0] ACK_LEN = 8'h08;

    // Trailer as a little-endian word: bytes F0, F0, A5, A5 on the wire.
    localparam logic [31:0] TRAILER = 32'hA5A5F0F0;

    // Flag value that allows unsolicited node messages.
    localparam logic [31:0] FLAG_TRUE = 32'h00000001;

    // Which exchange the node expects in the next frame.
    typedef enum logic [1:0] {
        PH_HOST_SIZE,
        PH_HOST_HDR,
        PH_NODE_SIZE,
        PH_NODE_HDR
    } phase_e;

endpackage : spi_msg_pkg

/* File: src/spi_bit_engine.sv */
`timescale 1ns/100ps

module spi_bit_engine (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic [7:0] i_tx_byte,
    output logic o_miso,
    output logic o_miso_oe,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_frame_start,
    output logic o_frame_end
);
    import spi_msg_pkg::*;

    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic mosi_s1_q, mosi_s2_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [2:0] bit_q;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, active;

    // Two flip-flops per pin; a third stage on clock and select finds edges.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
        end else begin
            sclk_s1_q <= i_sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q <= i_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            mosi_s1_q <= i_mosi;
            mosi_s2_q <= mosi_s1_q;
        end
    end

    // Mode 0: clock idles low, so a rise is the capture edge.
    assign active = ~cs_s2_q;
    assign sclk_rise = active & sclk_s2_q & ~sclk_s3_q;
    assign sclk_fall = active & ~sclk_s2_q & sclk_s3_q;
    assign cs_fall = ~cs_s2_q & cs_s3_q;
    assign cs_rise = cs_s2_q & ~cs_s3_q;

    // Receive side samples on the rising edge, most significant bit first.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_sh_q <= 8'h00;
            bit_q <= 3'h0;
            o_rx_byte <= 8'h00;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            if (cs_fall) begin
                bit_q <= 3'h0;
            end else if (sclk_rise) begin
                rx_sh_q <= {rx_sh_q[6:0], mosi_s2_q};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    o_rx_byte <= {rx_sh_q[6:0], mosi_s2_q};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // Transmit side changes on the falling edge; a new byte loads on the
    // fall after the eighth bit, so the caller has half a bit to supply it.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_sh_q <= 8'h00;
            o_miso <= 1'b0;
        end else if (cs_fall || (sclk_fall && bit_q == 3'h0)) begin
            tx_sh_q <= {i_tx_byte[6:0], 1'b0};
            o_miso <= i_tx_byte[7];
        end else if (sclk_fall) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            o_miso <= tx_sh_q[7];
        end
    end

    // The data line is driven only while the node is selected.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_miso_oe <= 1'b0;
            o_frame_start <= 1'b0;
            o_frame_end <= 1'b0;
        end else begin
            o_miso_oe <= active;
            o_frame_start <= cs_fall;
            o_frame_end <= cs_rise;
        end
    end

endmodule : spi_bit_engine

/* File: src/spi_message_framing.sv */
`timescale 1ns/100ps

// Operation
// - Link runs SPI mode 0, clock idles low.
// - Sample on rising edge, change on falling.
// - Every message opens with a size exchange.
// - Direction code 10 from host, 01 from node.
// - Length field after direction holds binary 10.
// - Size opcodes: 1001 host, 1011 node.
// - Header opcodes: 1010 host, 1100 node.
// - Size acknowledge reports free receive queue space.
// - Size request carries payload byte count.
// - Size exchange is followed by matching header exchange.
// - Header words carry constant byte one.
// - Host payload follows host header; node sends filler.
// - Multi-byte payload fields go least byte first.
// - Payload ends with fixed 32-bit trailer.
// - Payload opens with total length, then type.
// - Link-open type code is 0x4032.
// - Link-open flag one allows unsolicited node messages.
// - Node answers link-open with its own acknowledgement.
// - Node payload follows its header acknowledge word.
// - Host raises wake, waits for node ready.

module spi_message_framing #(
    parameter logic [7:0] RX_SPACE = spi_msg_pkg::RX_SPACE_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_host_wake_request,
    output logic o_node_ready_line,
    output logic o_node_attention_request,
    output logic [7:0] o_payload_byte,
    output logic o_payload_valid,
    output logic o_frame_ok,
    output logic o_frame_err,
    output logic [15:0] o_msg_type,
    output logic [7:0] o_host_size,
    output logic o_link_open,
    output logic o_unsolicited_en,
    output logic o_ack_sent
);
    import spi_msg_pkg::*;

    // A zero space would stall every host message forever.
    if (RX_SPACE == 8'h00) begin : g_bad_space
        $error("RX_SPACE must be nonzero");
    end

    logic [7:0] rx_byte;
    logic rx_valid_raw, start_raw, end_raw;
    logic rx_valid, frame_start, frame_end;
    logic wake_s1_q, wake_s2_q;
    phase_e phase_q;
    logic [7:0] idx_q;
    logic [7:0] value_q;
    logic cmd_ok_q;
    logic [7:0] pay_cnt_q;
    logic [15:0] len_q;
    logic [15:0] type_q;
    logic [31:0] flag_q;
    logic [31:0] tail_q;
    logic [7:0] tx_byte_q;
    logic pending_q;
    logic [7:0] pidx;
    logic hdr_frame_ok;

    // First command byte: direction, length code, opcode.
    function automatic logic [7:0] cmd_byte(input logic [1:0] dir,
                                            input logic [3:0] op);
        logic [7:0] b;
        b = 8'h00;
        b[CMD_DIR_LSB +: 2] = dir;
        b[CMD_LEN_LSB +: 2] = LEN_CODE;
        b[CMD_OP_LSB +: 4] = op;
        return b;
    endfunction : cmd_byte

    // Opcode that belongs to each exchange; both ends use the same one.
    function automatic logic [3:0] phase_op(input phase_e ph);
        logic [3:0] op;
        op = OP_HOST_SIZE;
        unique case (ph)
            PH_HOST_SIZE: op = OP_HOST_SIZE;
            PH_HOST_HDR: op = OP_HOST_HDR;
            PH_NODE_SIZE: op = OP_NODE_SIZE;
            PH_NODE_HDR: op = OP_NODE_HDR;
        endcase
        return op;
    endfunction : phase_op

    // Acknowledgement payload, laid out least significant byte first.
    function automatic logic [7:0] ack_byte(input logic [7:0] p);
        logic [7:0] b;
        b = 8'h00;
        case (p)
            8'h00: b = ACK_LEN;
            8'h01: b = 8'h00;
            8'h02: b = TYPE_ACK[7:0];
            8'h03: b = TYPE_ACK[15:8];
            8'h04: b = TRAILER[7:0];
            8'h05: b = TRAILER[15:8];
            8'h06: b = TRAILER[23:16];
            8'h07: b = TRAILER[31:24];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : ack_byte

    // Byte that the node shifts out at a given position of a frame.
    function automatic logic [7:0] tx_pick(input phase_e ph,
                                           input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        if (i == 8'h00) begin
            b = cmd_byte(DIR_NODE, phase_op(ph));
        end else if (i == 8'h01) begin
            unique case (ph)
                PH_HOST_SIZE: b = RX_SPACE;
                PH_NODE_SIZE: b = ACK_LEN;
                PH_HOST_HDR: b = HDR_CONST;
                PH_NODE_HDR: b = HDR_CONST;
            endcase
        end else if (ph == PH_NODE_HDR) begin
            b = ack_byte(i - 8'h02);
        end else begin
            b = 8'h00;
        end
        return b;
    endfunction : tx_pick

    spi_bit_engine u_engine (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .i_tx_byte(tx_byte_q),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .o_rx_byte(rx_byte),
        .o_rx_valid(rx_valid_raw),
        .o_frame_start(start_raw),
        .o_frame_end(end_raw)
    );

    // The wake line comes from the host, so it is synchronised first.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            o_node_ready_line <= 1'b0;
        end else begin
            wake_s1_q <= i_host_wake_request;
            wake_s2_q <= wake_s1_q;
            o_node_ready_line <= wake_s2_q;
        end
    end

    // Bus activity while the host is not awake is noise from an
    // undriven bus, so it never reaches the framing logic.
    assign rx_valid = rx_valid_raw & o_node_ready_line;
    assign frame_start = start_raw & o_node_ready_line;
    assign frame_end = end_raw & o_node_ready_line;
    assign pidx = idx_q - 8'h02;

    // A host header frame is good when its words match, the byte count
    // agrees with the length field and the last four bytes are the trailer.
    assign hdr_frame_ok = cmd_ok_q && idx_q >= 8'h02
        && len_q == {8'h00, pay_cnt_q}
        && tail_q == TRAILER;

    // Byte position within the current frame.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            idx_q <= 8'h00;
        end else if (frame_start) begin
            idx_q <= 8'h00;
        end else if (rx_valid && idx_q != 8'hFF) begin
            idx_q <= idx_q + 8'h01;
        end
    end

    // Check the host's command word against the expected exchange.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cmd_ok_q <= 1'b0;
            value_q <= 8'h00;
        end else if (frame_start) begin
            cmd_ok_q <= 1'b0;
        end else if (rx_valid && idx_q == 8'h00) begin
            cmd_ok_q <= rx_byte == cmd_byte(DIR_HOST, phase_op(phase_q));
        end else if (rx_valid && idx_q == 8'h01) begin
            value_q <= rx_byte;
            if (phase_q == PH_HOST_HDR || phase_q == PH_NODE_HDR) begin
                cmd_ok_q <= cmd_ok_q && rx_byte == HDR_CONST;
            end
        end
    end

    // Gather the host payload: length, type and flag little-endian,
    // plus a sliding window of the last four bytes for the trailer.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pay_cnt_q <= 8'h00;
            len_q <= 16'h0000;
            type_q <= 16'h0000;
            flag_q <= 32'h00000000;
            tail_q <= 32'h00000000;
        end else if (frame_start) begin
            pay_cnt_q <= 8'h00;
            len_q <= 16'h0000;
            type_q <= 16'h0000;
            flag_q <= 32'h00000000;
            tail_q <= 32'h00000000;
        end else if (rx_valid && idx_q >= 8'h02
                     && phase_q == PH_HOST_HDR) begin
            if (pay_cnt_q != 8'hFF) begin
                pay_cnt_q <= pay_cnt_q + 8'h01;
            end
            tail_q <= {rx_byte, tail_q[31:8]};
            case (pidx)
                8'h00: len_q[7:0] <= rx_byte;
                8'h01: len_q[15:8] <= rx_byte;
                8'h02: type_q[7:0] <= rx_byte;
                8'h03: type_q[15:8] <= rx_byte;
                8'h04: flag_q[7:0] <= rx_byte;
                8'h05: flag_q[15:8] <= rx_byte;
                8'h06: flag_q[23:16] <= rx_byte;
                8'h07: flag_q[31:24] <= rx_byte;
                default: ;
            endcase
        end
    end

    // Received payload bytes leave as a stream, filler from other frames
    // is not passed on.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_payload_byte <= 8'h00;
            o_payload_valid <= 1'b0;
        end else begin
            o_payload_valid <= rx_valid && idx_q >= 8'h02
                && phase_q == PH_HOST_HDR;
            if (rx_valid) begin
                o_payload_byte <= rx_byte;
            end
        end
    end

    // Exchange sequencing, advanced once per frame at deselect.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            phase_q <= PH_HOST_SIZE;
        end else if (frame_end) begin
            unique case (phase_q)
                PH_HOST_SIZE: begin
                    if (cmd_ok_q && idx_q >= 8'h02) begin
                        phase_q <= PH_HOST_HDR;
                    end
                end
                PH_HOST_HDR: begin
                    if (hdr_frame_ok && type_q == TYPE_LINK_OPEN) begin
                        phase_q <= PH_NODE_SIZE;
                    end else if (pending_q) begin
                        phase_q <= PH_NODE_SIZE;
                    end else begin
                        phase_q <= PH_HOST_SIZE;
                    end
                end
                PH_NODE_SIZE: begin
                    // A host with too little space is simply asked again
                    // on its next frame, after its own turn-around wait.
                    if (cmd_ok_q && idx_q >= 8'h02 && value_q >= ACK_LEN)
                    begin
                        phase_q <= PH_NODE_HDR;
                    end
                end
                PH_NODE_HDR: begin
                    if (cmd_ok_q && idx_q >= 8'h02) begin
                        phase_q <= PH_HOST_SIZE;
                    end else begin
                        phase_q <= PH_NODE_SIZE;
                    end
                end
            endcase
        end
    end

    // Next byte to send: the first byte of the next exchange at deselect,
    // otherwise the byte after the one just received.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_byte_q <= tx_pick(PH_HOST_SIZE, 8'h00);
        end else if (frame_end) begin
            unique case (phase_q)
                PH_HOST_SIZE: tx_byte_q <= (cmd_ok_q && idx_q >= 8'h02)
                    ? tx_pick(PH_HOST_HDR, 8'h00)
                    : tx_pick(PH_HOST_SIZE, 8'h00);
                PH_HOST_HDR: tx_byte_q <= ((hdr_frame_ok
                    && type_q == TYPE_LINK_OPEN) || pending_q)
                    ? tx_pick(PH_NODE_SIZE, 8'h00)
                    : tx_pick(PH_HOST_SIZE, 8'h00);
                PH_NODE_SIZE: tx_byte_q <= (cmd_ok_q && idx_q >= 8'h02
                    && value_q >= ACK_LEN)
                    ? tx_pick(PH_NODE_HDR, 8'h00)
                    : tx_pick(PH_NODE_SIZE, 8'h00);
                PH_NODE_HDR: tx_byte_q <= (cmd_ok_q && idx_q >= 8'h02)
                    ? tx_pick(PH_HOST_SIZE, 8'h00)
                    : tx_pick(PH_NODE_SIZE, 8'h00);
            endcase
        end else if (frame_start) begin
            tx_byte_q <= tx_pick(phase_q, 8'h01);
        end else if (rx_valid && idx_q != 8'hFF) begin
            tx_byte_q <= tx_pick(phase_q, idx_q + 8'h01);
        end
    end

    // Link-open handling and the pending acknowledgement. A new link-open
    // that lands as the acknowledgement completes keeps it pending.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pending_q <= 1'b0;
            o_unsolicited_en <= 1'b0;
            o_link_open <= 1'b0;
            o_ack_sent <= 1'b0;
        end else begin
            o_link_open <= 1'b0;
            o_ack_sent <= 1'b0;
            if (frame_end && phase_q == PH_HOST_HDR && hdr_frame_ok
                && type_q == TYPE_LINK_OPEN) begin
                pending_q <= 1'b1;
                o_link_open <= 1'b1;
                o_unsolicited_en <= flag_q == FLAG_TRUE;
            end else if (frame_end && phase_q == PH_NODE_HDR
                         && cmd_ok_q && idx_q >= 8'h02) begin
                pending_q <= 1'b0;
                o_ack_sent <= 1'b1;
            end
        end
    end

    // The node asks for the bus while its acknowledgement waits.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_node_attention_request <= 1'b0;
        end else begin
            o_node_attention_request <= pending_q;
        end
    end

    // Frame verdicts and the values the host announced.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_frame_ok <= 1'b0;
            o_frame_err <= 1'b0;
            o_msg_type <= 16'h0000;
            o_host_size <= 8'h00;
        end else begin
            o_frame_ok <= 1'b0;
            o_frame_err <= 1'b0;
            if (frame_end) begin
                if (phase_q == PH_HOST_HDR) begin
                    o_frame_ok <= hdr_frame_ok;
                    o_frame_err <= ~hdr_frame_ok;
                    o_msg_type <= type_q;
                end else begin
                    o_frame_ok <= cmd_ok_q && idx_q >= 8'h02;
                    o_frame_err <= ~(cmd_ok_q && idx_q >= 8'h02);
                end
                if (phase_q == PH_HOST_SIZE && cmd_ok_q) begin
                    o_host_size <= value_q;
                end
            end
        end
    end

endmodule : spi_message_framing

/* File: tb/spi_framing_props.sv */
`timescale 1ns/100ps
module spi_framing_props
    import spi_msg_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic i_host_wake_request,
    input wire logic o_node_ready_line,
    input wire logic o_node_attention_request,
    input wire logic [7:0] o_payload_byte,
    input wire logic o_payload_valid,
    input wire logic o_frame_ok,
    input wire logic o_frame_err,
    input wire logic [15:0] o_msg_type,
    input wire logic [7:0] o_host_size,
    input wire logic o_link_open,
    input wire logic o_unsolicited_en,
    input wire logic o_ack_sent
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Enable trails the select by three cycles: two synchroniser stages plus its own register.
    AST_OE_ON: assert property ((!i_cs_n)[*6] |-> o_miso_oe)
        else $error("miso enable low inside frame");
    AST_OE_OFF: assert property (i_cs_n[*6] |-> !o_miso_oe)
        else $error("miso enable high outside frame");
    AST_READY_UP: assert property (
        $rose(i_host_wake_request) |-> ##[2:4] o_node_ready_line)
        else $error("ready did not follow wake");
    AST_READY_DN: assert property (
        (!i_host_wake_request)[*5] |-> !o_node_ready_line)
        else $error("ready high without wake");
    // Data may only move after a falling clock edge or the fall of select.
    AST_MISO_HOLD: assert property (i_sclk[*3] |=> $stable(o_miso))
        else $error("miso moved while clock high");
    AST_VERDICT: assert property (
        (o_frame_ok || o_frame_err) |-> $past(i_cs_n, 3)
        ##1 !(o_frame_ok || o_frame_err))
        else $error("verdict not a single pulse after frame end");
    AST_OPEN_TYPE: assert property (
        o_link_open |-> ##[0:2] (o_msg_type == TYPE_LINK_OPEN))
        else $error("link open with wrong type");
    AST_ATTN_SET: assert property (
        o_link_open |-> ##[0:2] o_node_attention_request)
        else $error("no attention after link open");
    AST_ATTN_CLR: assert property (
        o_ack_sent |-> ##[0:2] !o_node_attention_request)
        else $error("attention stays after ack");
    AST_PV_GAP: assert property (
        o_payload_valid |=> (!o_payload_valid)[*8])
        else $error("payload strobes too close");
    AST_UNSOL: assert property (
        $changed(o_unsolicited_en) |-> ($past(o_link_open)
        || $past(o_link_open, 2)) or (##[0:2] o_link_open))
        else $error("flag changed without link open");
endmodule : spi_framing_props

/* File: tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    input wire logic i_sys_clk,
    input wire logic i_miso,
    input wire logic i_node_ready_line,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    output logic o_host_wake_request
);
    logic [7:0] tx_q [16];
    logic [7:0] rx_q [16];
    // Idle bus: clock low, select high.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        o_host_wake_request = 1'b0;
    end
    // Raise wake and wait a bounded time for ready.
    task automatic wake(output bit ok);
        o_host_wake_request <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge i_sys_clk);
            ok = (i_node_ready_line === 1'b1);
        end
    endtask : wake
    // One frame, MSB first, mode 0: change on fall, sample on rise.
    task automatic xfer(input int n);
        @(posedge i_sys_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                o_mosi <= tx_q[i][b];
                repeat (4) @(posedge i_sys_clk);
                o_sclk <= 1'b1;
                rx_q[i][b] = i_miso;
                repeat (4) @(posedge i_sys_clk);
                o_sclk <= 1'b0;
            end
        end
        repeat (4) @(posedge i_sys_clk);
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi; // Released line must not look stable.
        repeat (12) @(posedge i_sys_clk); // Shortened turn-around.
    endtask : xfer
endmodule : spi_host_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import spi_msg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, mosi, wake, miso, miso_oe, ready, attn, pv, ok, err;
    logic lo, unsol, ack;
    logic [7:0] pbyte, hsize;
    logic [15:0] mtype;
    int failures = 0;
    int check_count = 0;
    int n_ok = 0, n_err = 0, n_lo = 0, n_ack = 0, n_pv = 0;
    int c0 [5];
    bit up;
    always #50 sys_clk = ~sys_clk;
    spi_host_model host (.i_sys_clk(sys_clk), .i_miso(miso),
        .i_node_ready_line(ready), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .o_host_wake_request(wake));
    spi_message_framing dut (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(miso_oe), .i_host_wake_request(wake),
        .o_node_ready_line(ready), .o_node_attention_request(attn),
        .o_payload_byte(pbyte), .o_payload_valid(pv), .o_frame_ok(ok),
        .o_frame_err(err), .o_msg_type(mtype), .o_host_size(hsize),
        .o_link_open(lo), .o_unsolicited_en(unsol), .o_ack_sent(ack));
    // Count one-cycle pulses so tasks can judge them after the frame.
    always @(posedge sys_clk) begin
        n_ok <= n_ok + int'(ok === 1'b1);
        n_err <= n_err + int'(err === 1'b1);
        n_lo <= n_lo + int'(lo === 1'b1);
        n_ack <= n_ack + int'(ack === 1'b1);
        n_pv <= n_pv + int'(pv === 1'b1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic frame(input logic [7:0] b [$]);
        foreach (b[i]) host.tx_q[i] = b[i];
        host.xfer(b.size());
    endtask : frame
    task automatic rxchk(input logic [7:0] e [$]);
        foreach (e[i]) chk({8'h00, host.rx_q[i]}, {8'h00, e[i]});
    endtask : rxchk
    function automatic logic [15:0] dl();
        return {4'(n_ok - c0[0]), 4'(n_err - c0[1]), 4'(n_lo - c0[2]),
            4'(n_ack - c0[3])};
    endfunction : dl
    // Frames before ready is up must be ignored entirely.
    task automatic t_not_ready();
        c0 = '{n_ok, n_err, n_lo, n_ack, n_pv};
        frame('{8'hA9, 8'h0C});
        chk(dl(), 16'h0000);
        $display("not_ready done");
    endtask : t_not_ready
    task automatic t_link_open(input logic [7:0] flag);
        c0 = '{n_ok, n_err, n_lo, n_ack, n_pv};
        frame('{8'hA9, LINK_OPEN_LEN});
        rxchk('{8'h69, RX_SPACE_DEF});
        chk({8'h00, hsize}, {8'h00, LINK_OPEN_LEN});
        frame('{8'hAA, 8'h01, 8'h0C, 8'h00, 8'h32, 8'h40, flag, 8'h00,
            8'h00, 8'h00, 8'hF0, 8'hF0, 8'hA5, 8'hA5});
        rxchk('{8'h6A, HDR_CONST, 8'h00, 8'h00});
        chk(mtype, TYPE_LINK_OPEN);
        chk({pbyte, 6'h00, unsol, attn},
            {8'hA5, 6'h00, flag[0], 1'b1});
        chk({dl(), 8'(n_pv - c0[4])}, {16'h2010, 8'h0C});
        $display("link_open done");
    endtask : t_link_open
    // Node retries its size request while the host reports too little space.
    task automatic t_node_ack();
        c0 = '{n_ok, n_err, n_lo, n_ack, n_pv};
        frame('{8'hAB, 8'h04});
        rxchk('{8'h6B, ACK_LEN});
        frame('{8'hAB, 8'hFF});
        rxchk('{8'h6B, ACK_LEN});
        frame('{8'hAC, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00});
        rxchk('{8'h6C, HDR_CONST, ACK_LEN, 8'h00, 8'h30, 8'h00, 8'hF0,
            8'hF0, 8'hA5, 8'hA5});
        chk({4'(n_ack - c0[3]), 11'h000, attn}, 16'h1000);
        $display("node_ack done");
    endtask : t_node_ack
    // A wrong direction code is refused and the host size step remains.
    task automatic t_bad_word();
        c0 = '{n_ok, n_err, n_lo, n_ack, n_pv};
        frame('{8'h69, 8'h0C});
        chk(dl(), 16'h0100);
        $display("bad_word done");
    endtask : t_bad_word
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_not_ready();
        host.wake(up);
        if (!up) begin
            failures++;
            finish_test();
        end
        t_link_open(8'h01);
        t_node_ack();
        t_bad_word();
        t_link_open(8'h00);
        t_node_ack();
        finish_test();
    end
endmodule : testbench
bind spi_message_framing spi_framing_props props (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .i_host_wake_request(i_host_wake_request),
    .o_node_ready_line(o_node_ready_line),
    .o_node_attention_request(o_node_attention_request),
    .o_payload_byte(o_payload_byte), .o_payload_valid(o_payload_valid),
    .o_frame_ok(o_frame_ok), .o_frame_err(o_frame_err),
    .o_msg_type(o_msg_type), .o_host_size(o_host_size),
    .o_link_open(o_link_open), .o_unsolicited_en(o_unsolicited_en),
    .o_ack_sent(o_ack_sent));
